// ==== design/eshwp_pkg.sv ====
// constants and types shared by the eeprom shadow controller
package eshwp_pkg;
  // attribute offsets of the registers reached through the host port
  localparam logic [12:0] OFF_MISC   = 13'h03f0;
  localparam logic [12:0] OFF_CTRL   = 13'h1002;
  localparam logic [12:0] OFF_CFG0   = 13'h1020;
  localparam logic [12:0] OFF_CFG1   = 13'h1040;
  localparam logic [12:0] SHADOW_END = 13'h1000;
  // control register fields, a store is started by writing 8'h81
  localparam int          CTRL_STORE  = 7;
  localparam int          CTRL_LOAD   = 6;
  localparam int          CTRL_BUSY   = 1;
  localparam int          CTRL_UNLOCK = 0;
  localparam logic [7:0]  CTRL_WMASK  = 8'hc1;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam int          CFG_FUNC    = 0;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [7:0]  MISC_RESET  = 8'h00;
  localparam int          FIELD_W     = 5;
  // shadow geometry
  localparam logic [10:0] MISC_INDEX  = 11'h1f8;
  localparam logic [10:0] STEP_BYTE   = 11'h001;
  localparam logic [10:0] STEP_WORD   = 11'h002;
  localparam logic [11:0] SPAN_2K     = 12'h800;
  localparam logic [11:0] SPAN_512    = 12'h200;
  localparam int          START_SHIFT_2K  = 6;
  localparam int          START_SHIFT_512 = 4;
  // serial opcodes and field lengths
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  OP_EWX     = 2'h0;
  localparam logic [1:0]  EWEN_TAG   = 2'h3;
  localparam logic [4:0]  TAG_W      = 5'h02;
  localparam logic [4:0]  ALEN_2K_B  = 5'h0b;
  localparam logic [4:0]  ALEN_2K_W  = 5'h0a;
  localparam logic [4:0]  ALEN_512_B = 5'h09;
  localparam logic [4:0]  ALEN_512_W = 5'h08;
  localparam logic [4:0]  DLEN_B     = 5'h08;
  localparam logic [4:0]  DLEN_W     = 5'h10;
  localparam logic [4:0]  HDR_LEN    = 5'h03;
  localparam int          FRAME_W    = 30;
  localparam int          LEN_W      = 5;
  localparam int          DATA_W     = 16;
  localparam logic [1:0]  PH_LAST    = 2'h3;
  typedef enum logic [2:0] {ST_DIS, ST_LOAD, ST_IDLE, ST_EN, ST_STORE} eshwp_state_t;
  typedef enum logic [1:0] {CMD_EWDS, CMD_EWEN, CMD_READ, CMD_WRITE} eshwp_cmd_t;
  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_GAP, L_POLL} eshwp_lstate_t;
endpackage

// ==== design/eshwp_sync.sv ====
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module eshwp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk, // destination clock
  input  wire logic [W-1:0] d,   // asynchronous level
  output logic      [W-1:0] q    // synchronised level
);
  logic [W-1:0] meta_reg;

  // no reset: first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule

// ==== design/eshwp_link.sv ====
// serial engine on the eeprom link clock
`timescale 1ns/100ps
module eshwp_link (
  input  wire logic                         link_clk,   // link clock
  input  wire logic                         rst,        // system reset, synced here
  input  wire logic                         req_tgl,    // command request toggle
  input  wire logic [eshwp_pkg::FRAME_W-1:0] frame,     // bits, right justified
  input  wire logic [eshwp_pkg::LEN_W-1:0]   len,       // bit count of frame
  input  wire logic                         poll,       // wait for write ready
  output logic                              done_tgl,   // completion toggle
  output logic [eshwp_pkg::DATA_W-1:0]      rx_data,    // last bits shifted in
  output logic                              eeprom_cs,  // chip select
  output logic                              eeprom_sk,  // serial clock
  output logic                              eeprom_di,  // data to eeprom
  input  wire logic                         eeprom_do   // data from eeprom
);
  logic                        lrst;
  logic                        req_s;
  logic                        do_s;
  eshwp_pkg::eshwp_lstate_t    st_reg, st_next;
  logic                        seen_reg, seen_next;
  logic [eshwp_pkg::LEN_W-1:0] cnt_reg, cnt_next;
  logic [1:0]                  ph_reg, ph_next;
  logic                        cs_next, sk_next, di_next, done_next;
  logic [eshwp_pkg::DATA_W-1:0] rx_next;

  // reset, request and eeprom data all enter through two flops
  eshwp_sync #(.W(3)) u_sync (
    .clk (link_clk),
    .d   ({rst, req_tgl, eeprom_do}),
    .q   ({lrst, req_s, do_s})
  );

  // one bit per four link cycles, so synced data settles before sampling
  always_comb begin
    st_next   = st_reg;
    seen_next = seen_reg;
    cnt_next  = cnt_reg;
    ph_next   = ph_reg + 2'h1;
    cs_next   = eeprom_cs;
    sk_next   = eeprom_sk;
    di_next   = eeprom_di;
    done_next = done_tgl;
    rx_next   = rx_data;
    unique case (st_reg)
      eshwp_pkg::L_IDLE: begin
        ph_next = '0;
        cs_next = 1'b0;
        if (req_s != seen_reg) begin
          seen_next = req_s;
          cnt_next  = len;
          cs_next   = 1'b1;
          st_next   = eshwp_pkg::L_SHIFT;
        end
      end
      eshwp_pkg::L_SHIFT: begin
        if (ph_reg == '0) begin
          di_next = frame[cnt_reg - 5'd1];
          // previous bit has only now cleared the two sync flops
          rx_next = {rx_data[eshwp_pkg::DATA_W-2:0], do_s};
        end else if (ph_reg == eshwp_pkg::PH_LAST) begin
          sk_next = 1'b0;
          if (cnt_reg == 5'd1) begin
            cs_next = 1'b0;
            st_next = eshwp_pkg::L_GAP;
          end else begin
            cnt_next = cnt_reg - 5'd1;
          end
        end else begin
          sk_next = 1'b1;
        end
      end
      eshwp_pkg::L_GAP: begin
        di_next = 1'b0;
        // last bit of the frame lands one bit time late
        if (ph_reg == '0) begin
          rx_next = {rx_data[eshwp_pkg::DATA_W-2:0], do_s};
        end
        if (ph_reg == eshwp_pkg::PH_LAST) begin
          if (poll) begin
            cs_next = 1'b1;
            st_next = eshwp_pkg::L_POLL;
          end else begin
            done_next = ~done_tgl;
            st_next   = eshwp_pkg::L_IDLE;
          end
        end
      end
      eshwp_pkg::L_POLL: begin
        // eeprom holds its data line low until the word is programmed
        if (ph_reg == eshwp_pkg::PH_LAST && do_s) begin
          cs_next   = 1'b0;
          done_next = ~done_tgl;
          st_next   = eshwp_pkg::L_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st_reg    <= eshwp_pkg::L_IDLE;
      seen_reg  <= 1'b0;
      cnt_reg   <= '0;
      ph_reg    <= '0;
      eeprom_cs <= 1'b0;
      eeprom_sk <= 1'b0;
      eeprom_di <= 1'b0;
      done_tgl  <= 1'b0;
      rx_data   <= '0;
    end else begin
      st_reg    <= st_next;
      seen_reg  <= seen_next;
      cnt_reg   <= cnt_next;
      ph_reg    <= ph_next;
      eeprom_cs <= cs_next;
      eeprom_sk <= sk_next;
      eeprom_di <= di_next;
      done_tgl  <= done_next;
      rx_data   <= rx_next;
    end
  end
endmodule

// ==== design/eshwp_ctrl.sv ====
// shadow sram, host registers and store/load sequencer
`timescale 1ns/100ps
// Contract
// R01: writing 8'h81 to control starts a store
// R02: no store while any function configured
// R03: ready/busy low throughout a store
// R04: host makes no access while busy
// R05: disable opcode after reset and store end
// R06: enable opcode only with store and unlock
// R07: page field gives upper five address bits
// R08: locations below start never written
// R09: 2k part: 11-bit address, field 7 is 0x380
// R10: 512 part: 9-bit address, field 1f is 0x3e0
// R11: full store needs field zero, then rerun
// R12: real protection needs second store afterwards
// R13: host load also begins at start field
// R14: reset clears field, reset load is full
// R15: never issue protect-mode commands
// R16: load on reset and on host request
// R17: size and width select the eeprom geometry
// R18: word low then high byte, even locations
// R19: only read, write, enable, disable opcodes
// R20: wait ready per word, release after disable
// R21: store completion clears store and unlock
module eshwp_ctrl (
  input  wire logic        sys_clk,            // system clock, 100 MHz
  input  wire logic        rst,                // synchronous reset, active high
  input  wire logic        link_clk,           // serial engine clock
  input  wire logic [12:0] host_addr,          // attribute byte offset
  input  wire logic        host_wr,            // attribute write strobe
  input  wire logic        host_rd,            // attribute read strobe
  input  wire logic [7:0]  host_wdata,         // write data
  output logic      [7:0]  host_rdata,         // read data, registered
  output logic             ready_busy,         // low while storing
  input  wire logic        memory_size_select, // high: 16k-bit part
  input  wire logic        word_width_select,  // high: 16-bit words
  output logic             eeprom_cs,          // eeprom chip select
  output logic             eeprom_sk,          // eeprom serial clock
  output logic             eeprom_di,          // eeprom data in
  input  wire logic        eeprom_do           // eeprom data out
);
  logic [7:0] shadow_mem [0:2047];

  eshwp_pkg::eshwp_state_t state_reg, state_next;
  logic                   pend_reg, pend_next;
  logic                   req_reg, req_next;
  logic                   seen_reg, seen_next;
  logic [10:0]            idx_reg, idx_next;
  logic [7:0]             ctrl_reg, ctrl_next;
  logic [7:0]             misc_reg, misc_next;
  logic [7:0]             cfg0_reg, cfg0_next;
  logic [7:0]             cfg1_reg, cfg1_next;
  logic                   store_reg, store_next;
  logic                   ready_reg, ready_next;
  logic [7:0]             rdata_reg, rdata_next;
  logic [eshwp_pkg::FRAME_W-1:0] frame_reg, frame_next;
  logic [eshwp_pkg::LEN_W-1:0]   len_reg, len_next;
  logic                   poll_reg, poll_next;
  logic                   size_s, width_s, done_s;
  logic [eshwp_pkg::DATA_W-1:0] rx_data;
  logic                   done_tgl;
  logic                   done_evt, conf_any, last, issue;
  eshwp_pkg::eshwp_cmd_t  cmd;
  logic [10:0]            start_idx, step, eaddr;
  logic [4:0]             alen, dlen;
  logic [7:0]             lo_byte, hi_byte;
  logic                   we_a, we_b;
  logic [10:0]            wa_a, wa_b;
  logic [7:0]             wd_a, wd_b;

  // start of the page: five field bits above a size-dependent boundary
  function automatic logic [10:0] page_start(logic [4:0] f, logic big);
    return big ? (11'(f) << eshwp_pkg::START_SHIFT_2K)
               : (11'(f) << eshwp_pkg::START_SHIFT_512);
  endfunction

  // serial frame: start bit, opcode, address, optional data
  function automatic logic [eshwp_pkg::FRAME_W-1:0] mk_frame(
      eshwp_pkg::eshwp_cmd_t c, logic [10:0] a, logic [15:0] d,
      logic [4:0] al, logic [4:0] dl);
    logic [31:0] f;
    logic [31:0] ad;
    logic [1:0]  op;
    op = (c == eshwp_pkg::CMD_READ)  ? eshwp_pkg::OP_READ :
         (c == eshwp_pkg::CMD_WRITE) ? eshwp_pkg::OP_WRITE : eshwp_pkg::OP_EWX;
    ad = (c == eshwp_pkg::CMD_EWEN) ? (32'(eshwp_pkg::EWEN_TAG) << (al - eshwp_pkg::TAG_W)) :
         (c == eshwp_pkg::CMD_EWDS) ? 32'h0 : 32'(a);
    f  = (32'({1'b1, op}) << al) | ad;
    if (c == eshwp_pkg::CMD_READ || c == eshwp_pkg::CMD_WRITE) begin
      f = (f << dl) | ((c == eshwp_pkg::CMD_WRITE) ? 32'(d) : 32'h0);
    end
    return f[eshwp_pkg::FRAME_W-1:0];
  endfunction

  // straps and completion toggle come from outside this clock
  eshwp_sync #(.W(3)) u_sync (
    .clk (sys_clk),
    .d   ({memory_size_select, word_width_select, done_tgl}),
    .q   ({size_s, width_s, done_s})
  );

  eshwp_link u_link (
    .link_clk  (link_clk),
    .rst       (rst),
    .req_tgl   (req_reg),
    .frame     (frame_reg),
    .len       (len_reg),
    .poll      (poll_reg),
    .done_tgl  (done_tgl),
    .rx_data   (rx_data),
    .eeprom_cs (eeprom_cs),
    .eeprom_sk (eeprom_sk),
    .eeprom_di (eeprom_di),
    .eeprom_do (eeprom_do)
  );

  // geometry from the straps
  always_comb begin
    alen = size_s ? (width_s ? eshwp_pkg::ALEN_2K_W : eshwp_pkg::ALEN_2K_B)    // R17 R09
                  : (width_s ? eshwp_pkg::ALEN_512_W : eshwp_pkg::ALEN_512_B); // R10
    dlen      = width_s ? eshwp_pkg::DLEN_W : eshwp_pkg::DLEN_B;
    step      = width_s ? eshwp_pkg::STEP_WORD : eshwp_pkg::STEP_BYTE;
    start_idx = page_start(misc_reg[eshwp_pkg::FIELD_W-1:0], size_s); // R07
    eaddr     = width_s ? (idx_reg >> 1) : idx_reg;
    last      = ({1'b0, idx_reg} + {1'b0, step})
                == (size_s ? eshwp_pkg::SPAN_2K : eshwp_pkg::SPAN_512);
    conf_any  = cfg0_reg[eshwp_pkg::CFG_FUNC] | cfg1_reg[eshwp_pkg::CFG_FUNC];
    done_evt  = done_s != seen_reg;
    // the page field lives in a register, so store reads it from there
    lo_byte   = (idx_reg == eshwp_pkg::MISC_INDEX) ? misc_reg : shadow_mem[idx_reg];
    hi_byte   = shadow_mem[idx_reg + eshwp_pkg::STEP_BYTE];
  end

  // sequencer and register file next values
  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg;
    req_next   = req_reg;
    seen_next  = done_s;
    idx_next   = idx_reg;
    ctrl_next  = ctrl_reg;
    misc_next  = misc_reg;
    cfg0_next  = cfg0_reg;
    cfg1_next  = cfg1_reg;
    store_next = store_reg;
    rdata_next = rdata_reg;
    frame_next = frame_reg;
    len_next   = len_reg;
    poll_next  = poll_reg;
    issue      = 1'b0;
    cmd        = eshwp_pkg::CMD_EWDS;
    we_a = 1'b0; wa_a = '0; wd_a = '0;
    we_b = 1'b0; wa_b = '0; wd_b = '0;
    unique case (state_reg)
      eshwp_pkg::ST_DIS: begin
        cmd = eshwp_pkg::CMD_EWDS; // R05
        if (!pend_reg) begin
          issue = 1'b1;
        end else if (done_evt) begin
          pend_next = 1'b0;
          if (store_reg) begin
            store_next = 1'b0; // R20
            ctrl_next[eshwp_pkg::CTRL_STORE]  = 1'b0; // R21
            ctrl_next[eshwp_pkg::CTRL_UNLOCK] = 1'b0; // R21
            state_next = eshwp_pkg::ST_IDLE;
          end else begin
            idx_next   = start_idx; // R16 R14
            state_next = eshwp_pkg::ST_LOAD;
          end
        end
      end
      eshwp_pkg::ST_LOAD: begin
        cmd = eshwp_pkg::CMD_READ;
        if (!pend_reg) begin
          issue = 1'b1;
        end else if (done_evt) begin
          pend_next = 1'b0;
          we_a = 1'b1; wa_a = idx_reg; wd_a = rx_data[7:0]; // R18
          we_b = width_s; wa_b = idx_reg + eshwp_pkg::STEP_BYTE; wd_b = rx_data[15:8]; // R18
          if (idx_reg == eshwp_pkg::MISC_INDEX) misc_next = rx_data[7:0];
          if (last) begin
            ctrl_next[eshwp_pkg::CTRL_LOAD] = 1'b0;
            state_next = eshwp_pkg::ST_IDLE;
          end else begin
            idx_next = idx_reg + step;
          end
        end
      end
      eshwp_pkg::ST_IDLE: begin
        if (ctrl_reg[eshwp_pkg::CTRL_STORE] && ctrl_reg[eshwp_pkg::CTRL_UNLOCK]) begin // R01
          if (conf_any) begin
            // refused store reads back as cleared bits
            ctrl_next[eshwp_pkg::CTRL_STORE]  = 1'b0; // R02
            ctrl_next[eshwp_pkg::CTRL_UNLOCK] = 1'b0;
          end else begin
            store_next = 1'b1; // R03
            state_next = eshwp_pkg::ST_EN;
          end
        end else if (ctrl_reg[eshwp_pkg::CTRL_LOAD]) begin
          idx_next   = start_idx; // R13 R16
          state_next = eshwp_pkg::ST_LOAD;
        end
      end
      eshwp_pkg::ST_EN: begin
        cmd = eshwp_pkg::CMD_EWEN; // R06
        if (!pend_reg) begin
          issue = 1'b1;
        end else if (done_evt) begin
          pend_next  = 1'b0;
          idx_next   = start_idx; // R08
          state_next = eshwp_pkg::ST_STORE;
        end
      end
      eshwp_pkg::ST_STORE: begin
        cmd = eshwp_pkg::CMD_WRITE;
        if (!pend_reg && conf_any) begin
          state_next = eshwp_pkg::ST_DIS; // R02
        end else if (!pend_reg) begin
          issue = 1'b1;
        end else if (done_evt) begin
          pend_next = 1'b0; // R20
          if (last) state_next = eshwp_pkg::ST_DIS;
          else idx_next = idx_reg + step;
        end
      end
    endcase
    // only four opcodes exist in the command set
    if (issue) begin // R19 R15
      pend_next  = 1'b1;
      req_next   = ~req_reg;
      frame_next = mk_frame(cmd, eaddr, width_s ? {hi_byte, lo_byte} : {8'h00, lo_byte},
                            alen, dlen);
      len_next   = eshwp_pkg::HDR_LEN + alen
                   + ((cmd == eshwp_pkg::CMD_READ || cmd == eshwp_pkg::CMD_WRITE) ? dlen : 5'h00);
      poll_next  = cmd == eshwp_pkg::CMD_WRITE;
    end
    // host writes last, so a host set wins over a sequencer clear
    if (host_wr && !host_addr[0]) begin
      if (host_addr == eshwp_pkg::OFF_CTRL) begin
        ctrl_next = (host_wdata & eshwp_pkg::CTRL_WMASK) | (ctrl_next & ~host_wdata
                    & eshwp_pkg::CTRL_WMASK & {8{store_reg}});
      end else if (host_addr == eshwp_pkg::OFF_CFG0) begin
        cfg0_next = host_wdata;
      end else if (host_addr == eshwp_pkg::OFF_CFG1) begin
        cfg1_next = host_wdata;
      end else if (host_addr < eshwp_pkg::SHADOW_END) begin
        if (host_addr == eshwp_pkg::OFF_MISC) misc_next = host_wdata;
        if (!we_a) begin
          we_a = 1'b1; wa_a = host_addr[11:1]; wd_a = host_wdata;
        end
      end
    end
    if (host_rd) begin
      if (host_addr[0]) rdata_next = 8'h00;
      else if (host_addr == eshwp_pkg::OFF_CTRL)
        rdata_next = ctrl_reg | (8'(store_reg) << eshwp_pkg::CTRL_BUSY);
      else if (host_addr == eshwp_pkg::OFF_CFG0) rdata_next = cfg0_reg;
      else if (host_addr == eshwp_pkg::OFF_CFG1) rdata_next = cfg1_reg;
      else if (host_addr == eshwp_pkg::OFF_MISC) rdata_next = misc_reg;
      else if (host_addr < eshwp_pkg::SHADOW_END) rdata_next = shadow_mem[host_addr[11:1]];
      else rdata_next = 8'h00;
    end
    ready_next = !store_next; // R03 R20
  end

  // shadow sram, two write ports for the word load
  always_ff @(posedge sys_clk) begin
    if (we_a) shadow_mem[wa_a] <= wd_a;
    if (we_b) shadow_mem[wa_b] <= wd_b;
  end

  // reset starts with the disable opcode, then a full load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= eshwp_pkg::ST_DIS; // R05
      pend_reg  <= 1'b0;
      req_reg   <= 1'b0;
      seen_reg  <= 1'b0;
      idx_reg   <= '0;
      ctrl_reg  <= eshwp_pkg::CTRL_RESET;
      misc_reg  <= eshwp_pkg::MISC_RESET; // R14
      cfg0_reg  <= eshwp_pkg::CFG_RESET;
      cfg1_reg  <= eshwp_pkg::CFG_RESET;
      store_reg <= 1'b0;
      ready_reg <= 1'b1;
      rdata_reg <= 8'h00;
      frame_reg <= '0;
      len_reg   <= '0;
      poll_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      req_reg   <= req_next;
      seen_reg  <= seen_next;
      idx_reg   <= idx_next;
      ctrl_reg  <= ctrl_next;
      misc_reg  <= misc_next;
      cfg0_reg  <= cfg0_next;
      cfg1_reg  <= cfg1_next;
      store_reg <= store_next;
      ready_reg <= ready_next;
      rdata_reg <= rdata_next;
      frame_reg <= frame_next;
      len_reg   <= len_next;
      poll_reg  <= poll_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign ready_busy = ready_reg;

  // checks on the sequencer
  a_store_busy: assert property (@(posedge sys_clk) disable iff (rst) // R03
    (state_reg == eshwp_pkg::ST_STORE || state_reg == eshwp_pkg::ST_EN) |-> !ready_reg)
    else $error("ready high during store");
  a_cfg_blocks: assert property (@(posedge sys_clk) disable iff (rst) // R02
    $rose(store_reg) |-> $past(!conf_any))
    else $error("store began while configured");
  a_ewen_gate: assert property (@(posedge sys_clk) disable iff (rst) // R06
    (issue && cmd == eshwp_pkg::CMD_EWEN) |-> ctrl_reg[eshwp_pkg::CTRL_STORE]
      && ctrl_reg[eshwp_pkg::CTRL_UNLOCK] && store_reg)
    else $error("enable opcode without unlock");
  a_write_floor: assert property (@(posedge sys_clk) disable iff (rst) // R08
    (issue && cmd == eshwp_pkg::CMD_WRITE) |-> idx_reg >= start_idx && !conf_any)
    else $error("write below start or while configured");
  a_reset_ewds: assert property (@(posedge sys_clk) disable iff (rst) // R05
    $fell(rst) |-> state_reg == eshwp_pkg::ST_DIS ##1 pend_reg)
    else $error("no disable opcode after reset");
  a_store_clear: assert property (@(posedge sys_clk) disable iff (rst) // R21
    $fell(store_reg) |-> !ctrl_reg[eshwp_pkg::CTRL_STORE] && !ctrl_reg[eshwp_pkg::CTRL_UNLOCK])
    else $error("store bits left set");
  a_reset_field: assert property (@(posedge sys_clk) disable iff (rst) // R14
    $past(rst) |-> misc_reg == eshwp_pkg::MISC_RESET)
    else $error("page field not cleared by reset");
  a_load_start: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (state_reg != eshwp_pkg::ST_LOAD && state_next == eshwp_pkg::ST_LOAD)
      |=> idx_reg == $past(start_idx))
    else $error("load not at page start");
  a_ready_release: assert property (@(posedge sys_clk) disable iff (rst) // R20
    $rose(ready_reg) |-> $past(state_reg) == eshwp_pkg::ST_DIS && $past(done_evt))
    else $error("ready released before disable");
  c_store_done: cover property (@(posedge sys_clk) disable iff (rst) $rose(ready_reg));
  c_load_done: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == eshwp_pkg::ST_LOAD && state_next == eshwp_pkg::ST_IDLE);
  c_refused: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == eshwp_pkg::ST_IDLE && conf_any && ctrl_reg[eshwp_pkg::CTRL_STORE]);
endmodule

// ==== tb/eshwp_eeprom_model.sv ====
// behavioural serial eeprom, 256 x 16-bit, as seen by the controller
`timescale 1ns/100ps
module eshwp_eeprom_model (
  input  wire logic cs,      // chip select
  input  wire logic sk,      // serial clock
  input  wire logic di,      // data into the part
  output logic      dout_pin // data out of the part
);
  logic [15:0] mem [256];
  logic [31:0] sr;
  logic [15:0] rdd;
  logic [1:0]  op;
  logic        dq, wp, pol, last_dis;
  int          n, n_wr, n_en, n_bad;
  // blank-ish pattern so every word is recognisable
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {8'ha5, i[7:0]};
    {dq, wp, pol, last_dis} = 4'h0;
    {n, n_wr, n_en, n_bad} = '0;
  end
  // deselected line shows the inverse, never a stale level
  assign dout_pin = cs ? dq : ~dq;
  always @(posedge cs) n = 0;
  // busy after a write; no sk counting while ready is polled
  always @(negedge cs) begin
    pol = wp;
    if (wp) begin
      wp = 0;
      dq = 0;
      #400 dq = 1;
    end
  end
  // shift in msb first; decode after the address bits
  always @(posedge sk) if (cs && !pol) begin
    sr = {sr[30:0], di};
    n++;
    if (n == 3) begin
      op = sr[1:0];
      if (!sr[2]) n_bad++;
    end
    if (n > 11 && op == 2'h2) begin
      dq = rdd[15];
      rdd = rdd << 1;
    end
    if (n == 11) begin
      if (op == 2'h2) begin
        rdd = mem[sr[7:0]];
        dq = 0;
      end
      if (op == 2'h1) last_dis = 0;
      if (op == 2'h3 || (op == 2'h0 && (sr[7:6] == 2'h1 || sr[7:6] == 2'h2))) n_bad++;
      if (op == 2'h0 && sr[7:6] == 2'h3) begin
        n_en++;
        last_dis = 0;
      end
      if (op == 2'h0 && sr[7:6] == 2'h0) last_dis = 1;
    end
    if (n == 27 && op == 2'h1) begin
      mem[sr[23:16]] = sr[15:0];
      n_wr++;
      wp = 1;
    end
  end
endmodule

// ==== tb/tb_eeprom_shadow_write_protect.sv ====
// self-checking bench for the eeprom shadow controller
`timescale 1ns/100ps
module tb_eeprom_shadow_write_protect;
  logic        sys_clk, link_clk, rst, host_wr, host_rd, ssel, wsel, cs, sk, di, dout, rb, rd_seen;
  logic [12:0] host_addr;
  logic [12:0] cfg [2] = '{13'h1020, 13'h1040};
  logic [7:0]  host_wdata, host_rdata;
  logic [7:0]  sh [16];
  logic [7:0]  exp_q [$];
  string       nm_q [$];
  int          bad_count, total_checks, k;
  eshwp_ctrl dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .ready_busy(rb), .memory_size_select(ssel), .word_width_select(wsel),
    .eeprom_cs(cs), .eeprom_sk(sk), .eeprom_di(di), .eeprom_do(dout));
  eshwp_eeprom_model prom (.cs(cs), .sk(sk), .di(di), .dout_pin(dout));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // link clock unrelated in phase
  initial begin
    link_clk = 0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one idle cycle after each strobe keeps drivers single per step
  task automatic wr(logic [12:0] a, logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(posedge sys_clk) #1 host_wr = 0;
    @(posedge sys_clk) #1;
  endtask
  task automatic rd(logic [12:0] a, logic [7:0] e, string nm);
    host_addr = a;
    host_rd = 1;
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge sys_clk) #1 host_rd = 0;
    @(posedge sys_clk) #1;
  endtask
  // sequence over once cs rests for 300 cycles
  task automatic wait_idle();
    k = 0;
    for (int n = 0; n < 60000 && k < 300; n++) begin
      @(posedge sys_clk);
      k = cs ? 0 : k + 1;
    end
    #1;
    if (k < 300) begin
      bad_count++;
      summarize();
    end
  endtask
  // read data lands the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen) chk(nm_q.pop_front(), {8'h00, host_rdata}, {8'h00, exp_q.pop_front()});
    rd_seen <= host_rd;
  end
  initial begin
    {rst, host_wr, host_rd, ssel, wsel, rd_seen} = 6'h22;
    {host_addr, host_wdata, bad_count, total_checks} = '0;
    k = $urandom(32'h2b06);
    repeat (6) @(posedge sys_clk);
    #1 rst = 0;
    wait_idle();
    chk("dis_reset", {15'h0, prom.last_dis}, 16'h0001);
    rd(13'h0002, 8'ha5, "word0_hi");
    rd(13'h03fc, 8'hff, "word_last");
    rd(13'h03f0, 8'hfc, "page_load");
    foreach (cfg[i]) begin
      wr(cfg[i], 8'h01);
      wr(13'h1002, 8'h81);
      repeat (20) @(posedge sys_clk);
      #1;
      chk("rb_refused", {15'h0, rb}, 16'h0001);
      rd(13'h1002, 8'h00, "ctrl_refused");
      wr(cfg[i], 8'h00);
    end
    chk("refused_writes", 16'(prom.n_wr), 16'h0000);
    wr(13'h03f0, 8'h1f);
    for (int i = 0; i < 16; i++) begin
      sh[i] = (i == 8) ? 8'h1f : 8'($urandom);
      if (i != 8) wr(13'h03e0 + 13'(2 * i), sh[i]);
    end
    wr(13'h1002, 8'h81);
    repeat (2) @(posedge sys_clk);
    #1 chk("rb_store", {15'h0, rb}, 16'h0000);
    wait_idle();
    chk("rb_done", {15'h0, rb}, 16'h0001);
    rd(13'h1002, 8'h00, "ctrl_clear");
    for (int j = 0; j < 8; j++) chk("page", prom.mem[248 + j], {sh[2*j+1], sh[2*j]});
    for (int j = 0; j < 248; j++) chk("below", prom.mem[j], {8'ha5, 8'(j)});
    chk("word_count", 16'(prom.n_wr), 16'h0008);
    chk("enable_once", 16'(prom.n_en), 16'h0001);
    chk("dis_store", {15'h0, prom.last_dis}, 16'h0001);
    wr(13'h0000, 8'h3c);
    wr(13'h03e0, ~sh[0]);
    wr(13'h1002, 8'h40);
    wait_idle();
    rd(13'h0000, 8'h3c, "below_kept");
    rd(13'h03e0, sh[0], "page_reload");
    rd(13'h03f0, 8'h1f, "page_reg");
    rd(13'h1002, 8'h00, "load_clear");
    chk("bad_ops", 16'(prom.n_bad), 16'h0000);
    repeat (3) @(posedge sys_clk);
    summarize();
  end
endmodule
